// [clcd_pkg.sv]
package clcd_pkg;
    // Execution times as printed, and derived cycle counts at 50 MHz
    localparam int CLK_HZ = 50000000;
    localparam int T_SHORT_NS = 39000;
    localparam int T_DATA_NS = 43000;
    localparam int T_LONG_NS = 1530000;
    localparam int T_HALF_OSC_NS = 1852;
    localparam int CYC_SHORT = (T_SHORT_NS / 20 > 0) ? T_SHORT_NS / 20 : 1;
    localparam int CYC_DATA = (T_DATA_NS / 20 > 0) ? T_DATA_NS / 20 : 1;
    localparam int CYC_LONG = T_LONG_NS / 20;
    localparam int CYC_HALF_OSC = (T_HALF_OSC_NS + 19) / 20;
    // Text and glyph RAM geometry
    localparam logic [6:0] TEXT_LAST_1L = 7'h4f;
    localparam logic [6:0] TEXT_LAST_L1 = 7'h27;
    localparam logic [6:0] TEXT_FIRST_L2 = 7'h40;
    localparam logic [6:0] TEXT_LAST_L2 = 7'h67;
    localparam logic [7:0] SPACE_CODE = 8'h20;
    localparam int TEXT_SIZE = 128;
    localparam int GLYPH_SIZE = 64;
    // Reset values of configuration
    localparam logic RST_WIDTH8 = 1'b1;
    localparam logic RST_INC = 1'b1;

    typedef enum logic [1:0] {
        CLCD_IDLE = 2'b00,
        CLCD_BUSY = 2'b01,
        CLCD_CLEAR = 2'b11
    } clcd_state_t;

    // Host-side bus pins; the data pin is split into in, out and enable
    typedef struct packed {
        logic register_select;
        logic read_not_write;
        logic strobe;
        logic [7:0] data;
    } clcd_bus_in_t;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] data_oe;
    } clcd_bus_out_t;

    typedef struct packed {
        logic bus_width_select;
        logic two_line;
        logic tall_font;
        logic increment;
        logic whole_display_shift;
        logic display_on;
        logic cursor_on;
        logic blink_on;
        logic [6:0] display_offset;
    } clcd_cfg_t;
endpackage

// [clcd_port.sv]
`timescale 1ns/1ps
// Functional notes
// RULE1 - Byte 001xxxxx is function set, 39 us
// RULE2 - Width bit: 1 byte, 0 two nibbles
// RULE3 - Line bit: 0 one line, 1 two
// RULE4 - Font bit: 0 5x7, 1 5x10
// RULE5 - 01xxxxxx loads glyph address, 39 us
// RULE6 - 1xxxxxxx loads text address
// RULE7 - One line: text 00H to 4FH
// RULE8 - Two lines: 00H-27H and 40H-67H
// RULE9 - Status read gives busy and address
// RULE10 - Busy high while executing, else low
// RULE11 - Host waits busy low plus half period
// RULE12 - Data write stores into selected RAM
// RULE13 - Data write steps address by direction
// RULE14 - Data read returns byte, steps address
// RULE15 - Host loads address before first read
// RULE16 - Cursor shift prefetches text read data
// RULE17 - No display shift after glyph read
// RULE18 - Clear fills spaces, address zero, 1.53 ms
// RULE19 - Home zeroes address, unshifts, 1.53 ms
// RULE20 - Entry, display, shift take 39 us
// RULE21 - Nibble mode: upper lines, high first
// RULE22 - Nibble mode busy after second nibble
// RULE23 - Direction 1 increments; shift bit shifts
// RULE24 - Display off blanks; cursor, blink bits
// RULE25 - Nibble mode: every access is two nibbles
module clcd_port #(
    parameter int LONG_CYCLES = clcd_pkg::CYC_LONG
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Host bus
    input wire clcd_pkg::clcd_bus_in_t bus_i,
    output clcd_pkg::clcd_bus_out_t bus_o,
    // Display-facing configuration and status
    output clcd_pkg::clcd_cfg_t cfg_o,
    output logic busy_indicator_o,
    output logic [6:0] address_pointer_o
);
    import clcd_pkg::*;

    typedef struct packed {
        clcd_state_t st;
        logic [20:0] cnt;
        logic strobe_d;
        logic phase;
        logic [3:0] hi_nib;
        logic glyph_sel;
        logic [6:0] ac;
        logic [7:0] rd_reg;
        logic [7:0] dout;
        logic drive;
        clcd_cfg_t cfg;
    } clcd_regs_t;

    clcd_regs_t r;
    clcd_regs_t next_r;
    logic [7:0] text_ram [TEXT_SIZE];
    logic [7:0] glyph_ram [GLYPH_SIZE];

    // Step address within the legal text range for the line mode
    function automatic logic [6:0] clcd_step(input logic [6:0] a, input logic inc,
                                             input logic glyph, input logic two);
        logic [6:0] n;
        n = inc ? a + 7'h01 : a - 7'h01;
        if (glyph) begin
            n[6] = 1'b0;
        end else if (!two) begin
            if (inc && a == TEXT_LAST_1L) n = 7'h00; // RULE7
            if (!inc && a == 7'h00) n = TEXT_LAST_1L; // RULE7
        end else begin
            if (inc && a == TEXT_LAST_L1) n = TEXT_FIRST_L2; // RULE8
            if (inc && a == TEXT_LAST_L2) n = 7'h00; // RULE8
            if (!inc && a == TEXT_FIRST_L2) n = TEXT_LAST_L1; // RULE8
            if (!inc && a == 7'h00) n = TEXT_LAST_L2; // RULE8
        end
        return n;
    endfunction

    logic fall;
    logic full;
    logic [7:0] word;
    logic wr_text;
    logic wr_glyph;
    logic [6:0] clr_addr;
    logic [7:0] text_q;
    logic [7:0] glyph_q;

    // Strobe falling edge latches; in nibble mode only the second nibble completes
    assign fall = r.strobe_d && !bus_i.strobe;
    assign full = fall && (r.cfg.bus_width_select || r.phase); // RULE2 RULE25
    assign word = r.cfg.bus_width_select ? bus_i.data : {r.hi_nib, bus_i.data[7:4]}; // RULE21
    assign text_q = text_ram[r.ac];
    assign glyph_q = glyph_ram[r.ac[5:0]];
    assign clr_addr = r.cnt[6:0];

    always_comb begin
        next_r = r;
        wr_text = 1'b0;
        wr_glyph = 1'b0;
        next_r.strobe_d = bus_i.strobe;
        if (r.cnt != '0) next_r.cnt = r.cnt - 21'd1;
        unique case (r.st)
            CLCD_IDLE: begin end
            CLCD_BUSY: if (r.cnt == 21'd1) next_r.st = CLCD_IDLE; // RULE10
            CLCD_CLEAR: begin
                wr_text = 1'b1; // RULE18
                if (r.cnt == 21'd1) next_r.st = CLCD_IDLE;
            end
            default: next_r.st = CLCD_IDLE;
        endcase
        // Read data drives while the strobe is high
        next_r.drive = bus_i.strobe && bus_i.read_not_write;
        if (bus_i.strobe && !r.strobe_d && bus_i.read_not_write) begin
            if (!bus_i.register_select)
                next_r.dout = {r.st != CLCD_IDLE, r.ac}; // RULE9
            else
                next_r.dout = r.rd_reg; // RULE14
            if (!r.cfg.bus_width_select && r.phase)
                next_r.dout = {next_r.dout[3:0], 4'h0}; // RULE21
        end else if (bus_i.strobe && !r.strobe_d && !r.cfg.bus_width_select && r.phase) begin
            next_r.dout = {r.dout[3:0], 4'h0};
        end
        if (fall && !r.cfg.bus_width_select) begin
            next_r.phase = !r.phase; // RULE25
            if (!r.phase) next_r.hi_nib = bus_i.data[7:4]; // RULE21
            if (!r.phase && bus_i.read_not_write) next_r.dout = {r.dout[3:0], 4'h0};
        end
        // Host must wait for busy low before writing; a status read never starts work, a data read sets busy
        if (full && !bus_i.read_not_write && r.st == CLCD_IDLE) begin // RULE11 RULE22
            next_r.st = CLCD_BUSY;
            next_r.cnt = 21'(CYC_SHORT); // RULE20
            if (bus_i.register_select) begin
                wr_text = !r.glyph_sel; // RULE12
                wr_glyph = r.glyph_sel; // RULE12
                next_r.cnt = 21'(CYC_DATA);
                next_r.ac = clcd_step(r.ac, r.cfg.increment, r.glyph_sel, r.cfg.two_line); // RULE13
                if (!r.glyph_sel && r.cfg.whole_display_shift) // RULE23
                    next_r.cfg.display_offset = r.cfg.increment ? r.cfg.display_offset + 7'h01
                                                                : r.cfg.display_offset - 7'h01;
            end else if (word[7]) begin
                next_r.ac = word[6:0]; // RULE6
                next_r.glyph_sel = 1'b0;
                next_r.rd_reg = text_ram[word[6:0]]; // RULE16
            end else if (word[6]) begin
                next_r.ac = {1'b0, word[5:0]}; // RULE5
                next_r.glyph_sel = 1'b1;
                next_r.rd_reg = glyph_ram[word[5:0]];
            end else if (word[5]) begin
                next_r.cfg.bus_width_select = word[4]; // RULE1 RULE2
                next_r.cfg.two_line = word[3]; // RULE3
                next_r.cfg.tall_font = word[2]; // RULE4
                next_r.phase = 1'b0;
            end else if (word[4]) begin
                if (!word[3]) begin
                    next_r.ac = clcd_step(r.ac, word[2], r.glyph_sel, r.cfg.two_line);
                    if (!r.glyph_sel)
                        next_r.rd_reg = text_ram[clcd_step(r.ac, word[2], 1'b0,
                                                           r.cfg.two_line)]; // RULE16
                end else begin
                    next_r.cfg.display_offset = word[2] ? r.cfg.display_offset - 7'h01
                                                        : r.cfg.display_offset + 7'h01;
                end
            end else if (word[3]) begin
                next_r.cfg.display_on = word[2]; // RULE24
                next_r.cfg.cursor_on = word[1]; // RULE24
                next_r.cfg.blink_on = word[0]; // RULE24
            end else if (word[2]) begin
                next_r.cfg.increment = word[1]; // RULE23
                next_r.cfg.whole_display_shift = word[0]; // RULE23
            end else if (word[1]) begin
                next_r.ac = 7'h00; // RULE19
                next_r.glyph_sel = 1'b0;
                next_r.cfg.display_offset = 7'h00; // RULE19
                next_r.cnt = 21'(LONG_CYCLES);
            end else if (word[0]) begin
                next_r.st = CLCD_CLEAR;
                next_r.ac = 7'h00; // RULE18
                next_r.glyph_sel = 1'b0;
                next_r.cfg.display_offset = 7'h00;
                next_r.cfg.increment = 1'b1;
                next_r.cnt = 21'(LONG_CYCLES); // RULE18
            end
        end else if (full && bus_i.read_not_write && bus_i.register_select) begin
            // Data read steps the pointer and refetches
            next_r.ac = clcd_step(r.ac, r.cfg.increment, r.glyph_sel, r.cfg.two_line); // RULE14
            next_r.rd_reg = r.glyph_sel ? glyph_ram[next_r.ac[5:0]] : text_ram[next_r.ac];
            next_r.st = CLCD_BUSY;
            next_r.cnt = 21'(CYC_DATA);
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '0;
            r.cfg.bus_width_select <= RST_WIDTH8;
            r.cfg.increment <= RST_INC;
        end else begin
            r <= next_r;
        end
    end

    // RAMs are kept out of reset so they can map to memory
    always_ff @(posedge clk_sys_i) begin
        if (r.st == CLCD_CLEAR) begin
            text_ram[clr_addr] <= SPACE_CODE; // RULE18
        end else if (wr_text) begin
            text_ram[r.ac] <= word;
        end
        if (wr_glyph) glyph_ram[r.ac[5:0]] <= word;
    end

    assign bus_o.data = r.dout;
    assign bus_o.data_oe = r.drive ? (r.cfg.bus_width_select ? 8'hff : 8'hf0) : 8'h00;
    assign cfg_o = r.cfg;
    assign busy_indicator_o = r.st != CLCD_IDLE;
    assign address_pointer_o = r.ac;

    // Accepted instruction or data write this cycle, shared by the checks
    logic instr_go;
    logic data_go;
    assign instr_go = full && !bus_i.read_not_write && !bus_i.register_select
        && r.st == CLCD_IDLE;
    assign data_go = full && !bus_i.read_not_write && bus_i.register_select
        && r.st == CLCD_IDLE;

    busy_after_write_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        full && !bus_i.read_not_write && r.st == CLCD_IDLE |=> busy_indicator_o) // RULE10
        else $error("busy not raised after instruction");
    short_time_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        full && !bus_i.read_not_write && !bus_i.register_select && r.st == CLCD_IDLE
        && word[7:2] == 6'b000011 |=> r.cnt == 21'(CYC_SHORT)) // RULE20
        else $error("display control time wrong");
    data_time_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        full && !bus_i.read_not_write && bus_i.register_select && r.st == CLCD_IDLE
        |=> r.cnt == 21'(CYC_DATA)) // RULE12
        else $error("data write time wrong");
    nibble_first_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        fall && !r.cfg.bus_width_select && !r.phase && r.st == CLCD_IDLE
        |=> !busy_indicator_o) // RULE22
        else $error("busy after first nibble");
    func_set_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        full && !bus_i.read_not_write && !bus_i.register_select && r.st == CLCD_IDLE
        && word[7:5] == 3'b001 |=> r.cfg.two_line == $past(word[3])) // RULE1 RULE3
        else $error("function set not captured");
    text_load_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        full && !bus_i.read_not_write && !bus_i.register_select && r.st == CLCD_IDLE
        && word[7] |=> r.ac == $past(word[6:0]) && !r.glyph_sel) // RULE6
        else $error("text address not loaded");
    glyph_load_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        full && !bus_i.read_not_write && !bus_i.register_select && r.st == CLCD_IDLE
        && word[7:6] == 2'b01 |=> r.ac[6] == 1'b0 && r.glyph_sel) // RULE5
        else $error("glyph address not loaded");
    range_one_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !r.cfg.two_line && !r.glyph_sel && $past(r.ac) <= TEXT_LAST_1L
        && $past(data_go) |-> r.ac <= TEXT_LAST_1L) // RULE7
        else $error("text address out of range");
    clear_home_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        r.st == CLCD_CLEAR |-> r.ac == 7'h00 || $past(r.st) == CLCD_IDLE) // RULE18
        else $error("clear left address set");

    // Decode checks
    status_word_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE9
        bus_i.strobe && !r.strobe_d && bus_i.read_not_write && !bus_i.register_select
        && r.cfg.bus_width_select |=> bus_o.data == {$past(busy_indicator_o), $past(r.ac)})
        else $error("status word wrong");
    busy_count_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE10
        busy_indicator_o |-> r.cnt != 21'd0)
        else $error("busy with no time left");
    refuse_busy_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE10
        full && !bus_i.read_not_write && r.st != CLCD_IDLE
        |=> r.ac == $past(r.ac) && r.cfg == $past(r.cfg))
        else $error("write taken while busy");
    width_cap_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE2 RULE4
        instr_go && word[7:5] == 3'b001 |=> r.cfg.bus_width_select == $past(word[4])
        && r.cfg.tall_font == $past(word[2]))
        else $error("width or font not captured");
    entry_mode_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE23
        instr_go && word[7:2] == 6'b000001 |=> r.cfg.increment == $past(word[1])
        && r.cfg.whole_display_shift == $past(word[0]))
        else $error("entry mode not captured");
    display_ctrl_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE24
        instr_go && word[7:3] == 5'b00001
        |=> {r.cfg.display_on, r.cfg.cursor_on, r.cfg.blink_on} == $past(word[2:0]))
        else $error("display control not captured");
    home_zero_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE19
        instr_go && word[7:1] == 7'h01 |=> r.ac == 7'h00 && r.cfg.display_offset == 7'h00)
        else $error("home left address or shift");
    clear_start_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE18
        instr_go && word == 8'h01 |=> r.st == CLCD_CLEAR && r.cfg.increment)
        else $error("clear did not start");
    load_prefetch_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE16
        instr_go && word[7] |=> r.rd_reg == text_ram[r.ac])
        else $error("text load did not prefetch");
    nibble_pair_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE25
        fall && !r.cfg.bus_width_select |=> r.phase != $past(r.phase))
        else $error("nibble phase stuck");

    // Data path checks
    text_write_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE12
        data_go && !r.glyph_sel |=> text_ram[$past(r.ac)] == $past(word))
        else $error("text byte not stored");
    glyph_write_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE12
        data_go && r.glyph_sel |=> glyph_ram[$past(r.ac[5:0])] == $past(word))
        else $error("glyph byte not stored");
    glyph_step_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE13
        data_go && r.glyph_sel && r.cfg.increment
        |=> r.ac == {1'b0, $past(r.ac[5:0]) + 6'h01})
        else $error("glyph address not incremented");
    glyph_back_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE13
        data_go && r.glyph_sel && !r.cfg.increment
        |=> r.ac == {1'b0, $past(r.ac[5:0]) - 6'h01})
        else $error("glyph address not decremented");
    two_step_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE8
        data_go && !r.glyph_sel && r.cfg.two_line && r.cfg.increment
        && r.ac == TEXT_LAST_L1 |=> r.ac == TEXT_FIRST_L2)
        else $error("first line did not wrap to second");
    read_busy_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE14
        full && bus_i.read_not_write && bus_i.register_select
        |=> busy_indicator_o && r.cnt == 21'(CYC_DATA))
        else $error("data read time wrong");

    clear_seen_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        r.st == CLCD_CLEAR);
    nibble_seen_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        full && !r.cfg.bus_width_select);
    read_seen_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        full && bus_i.read_not_write && bus_i.register_select);
    home_seen_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        instr_go && word[7:1] == 7'h01);
    glyph_write_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        data_go && r.glyph_sel);
endmodule // clcd_port

// [clcd_host.sv]
`timescale 1ns/1ps
module clcd_host (
    // Clock
    input wire logic clk_sys_i,
    // Bus toward the port
    output clcd_pkg::clcd_bus_in_t bus_o,
    input wire clcd_pkg::clcd_bus_out_t bus_i
);
    import clcd_pkg::*;
    logic nib = 1'b0;
    logic rs = 1'b0;
    logic rw = 1'b0;
    logic stb = 1'b0;
    logic [7:0] drv = 8'h00;

    // Wire level: port wins where enabled, else host or its released pattern
    always_comb begin
        bus_o.register_select = rs;
        bus_o.read_not_write = rw;
        bus_o.strobe = stb;
        for (int k = 0; k < 8; k++) begin
            bus_o.data[k] = bus_i.data_oe[k] ? bus_i.data[k] : drv[k];
        end
    end

    task automatic xfer(input logic r_s, input logic r_w, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk_sys_i);
        rs <= r_s;
        rw <= r_w;
        drv <= r_w ? ~drv : d;
        stb <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        q = bus_o.data;
        stb <= 1'b0;
        @(posedge clk_sys_i);
        drv <= ~drv;
    endtask

    task automatic acc(input logic r_s, input logic r_w, input logic [7:0] d,
                       output logic [7:0] q);
        logic [7:0] h;
        logic [7:0] l;
        if (nib) begin
            xfer(r_s, r_w, {d[7:4], 4'h0}, h);
            xfer(r_s, r_w, {d[3:0], 4'h0}, l);
            q = {h[7:4], l[7:4]};
        end else begin
            xfer(r_s, r_w, d, q);
        end
        if (!r_s && !r_w && d[7:5] == 3'b001) begin
            nib = ~d[4];
        end
    endtask

    task automatic wait_idle(output logic ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int n = 0; n < 1000 && !ok; n++) begin
            acc(1'b0, 1'b1, 8'h00, s);
            ok = (s[7] === 1'b0);
        end
        repeat (CYC_HALF_OSC) @(posedge clk_sys_i);
    endtask
endmodule // clcd_host

// [tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb;
    import clcd_pkg::*;
    typedef struct packed {
        logic [1:0] op;
        logic [7:0] d;
        logic [6:0] ac;
        logic [7:0] q;
    } clcd_row_t;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    clcd_bus_in_t bus_in;
    clcd_bus_out_t bus_out;
    clcd_cfg_t cfg;
    logic busy;
    logic [6:0] ac;
    logic [7:0] q;
    logic ok;
    int n;
    int n_errors = 0;
    int cmp_count = 0;
    // Each row: {rs, rw}, data, pointer after, read data
    clcd_row_t rows [21] = '{
        '{2'b00, 8'h38, 7'h00, 8'h00},
        '{2'b00, 8'h0c, 7'h00, 8'h00},
        '{2'b00, 8'h06, 7'h00, 8'h00},
        '{2'b00, 8'ha7, 7'h27, 8'h00},
        '{2'b10, 8'h41, 7'h40, 8'h00},
        '{2'b10, 8'h42, 7'h41, 8'h00},
        '{2'b00, 8'ha7, 7'h27, 8'h00},
        '{2'b11, 8'h00, 7'h40, 8'h41},
        '{2'b11, 8'h00, 7'h41, 8'h42},
        '{2'b00, 8'h45, 7'h05, 8'h00},
        '{2'b10, 8'h1f, 7'h06, 8'h00},
        '{2'b00, 8'h45, 7'h05, 8'h00},
        '{2'b11, 8'h00, 7'h06, 8'h1f},
        '{2'b00, 8'h04, 7'h06, 8'h00},
        '{2'b10, 8'h33, 7'h05, 8'h00},
        '{2'b00, 8'h14, 7'h06, 8'h00},
        '{2'b00, 8'h10, 7'h05, 8'h00},
        '{2'b00, 8'h02, 7'h00, 8'h00},
        '{2'b00, 8'h01, 7'h00, 8'h00},
        '{2'b00, 8'h80, 7'h00, 8'h00},
        '{2'b11, 8'h00, 7'h01, 8'h20}
    };

    clcd_port #(.LONG_CYCLES(200)) clcd_port_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .bus_i(bus_in), .bus_o(bus_out), .cfg_o(cfg), .busy_indicator_o(busy),
        .address_pointer_o(ac));
    clcd_host clcd_host_i (.clk_sys_i(clk_sys_i), .bus_o(bus_in), .bus_i(bus_out));

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Busy cycles counted from the first high sample
    task automatic busy_len(output int c);
        c = 0;
        for (int k = 0; k < 5 && busy !== 1'b1; k++) @(posedge clk_sys_i);
        while (busy === 1'b1 && c < 100000) begin
            @(posedge clk_sys_i);
            c++;
        end
        repeat (CYC_HALF_OSC) @(posedge clk_sys_i);
    endtask

    initial begin
        repeat (90000) @(posedge clk_sys_i);
        n_errors++;
        give_verdict();
    end

    initial begin
        repeat (12) @(posedge clk_sys_i);
        `CHK({busy, ac, bus_out.data_oe, cfg.bus_width_select, cfg.increment}, 18'h00003)
        nrst_i <= 1'b1;
        $display("test reset done");
        foreach (rows[i]) begin
            clcd_host_i.acc(rows[i].op[1], rows[i].op[0], rows[i].d, q);
            clcd_host_i.wait_idle(ok);
            `CHK(ok, 1'b1)
            if (rows[i].op[0]) `CHK(q, rows[i].q)
            clcd_host_i.acc(1'b0, 1'b1, 8'h00, q);
            `CHK(q, {1'b0, rows[i].ac})
            `CHK(ac, rows[i].ac)
        end
        `CHK({cfg.bus_width_select, cfg.two_line, cfg.tall_font, cfg.display_on}, 4'hd)
        $display("test table done");
        // Write while busy is dropped; status still answers
        clcd_host_i.acc(1'b1, 1'b0, 8'h55, q);
        clcd_host_i.acc(1'b0, 1'b1, 8'h00, q);
        `CHK(q, 8'h82)
        clcd_host_i.acc(1'b0, 1'b0, 8'hc0, q);
        clcd_host_i.wait_idle(ok);
        `CHK(ac, 7'h02)
        clcd_host_i.acc(1'b0, 1'b0, 8'h0f, q);
        busy_len(n);
        `CHK(n, CYC_SHORT)
        `CHK({cfg.cursor_on, cfg.blink_on}, 2'b11)
        clcd_host_i.acc(1'b1, 1'b0, 8'h66, q);
        busy_len(n);
        `CHK(n, CYC_DATA)
        clcd_host_i.acc(1'b0, 1'b0, 8'h02, q);
        busy_len(n);
        `CHK(n, 200)
        $display("test timing done");
        clcd_host_i.acc(1'b0, 1'b0, 8'h28, q);
        clcd_host_i.wait_idle(ok);
        `CHK(cfg.bus_width_select, 1'b0)
        clcd_host_i.xfer(1'b0, 1'b0, 8'h80, q);
        repeat (5) @(posedge clk_sys_i);
        `CHK(busy, 1'b0)
        clcd_host_i.xfer(1'b0, 1'b0, 8'h50, q);
        repeat (3) @(posedge clk_sys_i);
        `CHK(busy, 1'b1)
        clcd_host_i.wait_idle(ok);
        clcd_host_i.acc(1'b0, 1'b1, 8'h00, q);
        `CHK(q, 8'h05)
        clcd_host_i.acc(1'b0, 1'b0, 8'h24, q);
        clcd_host_i.wait_idle(ok);
        `CHK({cfg.two_line, cfg.tall_font}, 2'b01)
        clcd_host_i.acc(1'b0, 1'b0, 8'hcf, q);
        clcd_host_i.wait_idle(ok);
        clcd_host_i.acc(1'b1, 1'b0, 8'h77, q);
        clcd_host_i.wait_idle(ok);
        `CHK(ac, 7'h00)
        $display("test nibble done");
        give_verdict();
    end
endmodule // tb
